// *** src/rtc_i2c_slave_interface.sv ***
// Purpose: two-wire target interface giving a host access to 16 clock registers
// Assumes: serial clock well below clk/4; register read data valid same cycle
// Notes: data line is open drain; the serial clock is never held low
// Function
// RQ1: idle bus has both lines high and released by everyone.
// RQ2: data changes only while the serial clock is low.
// RQ3: data falling with clock high is a start; begin an access.
// RQ4: data rising with clock high is a stop; end the access.
// RQ5: only the master makes start and stop conditions.
// RQ6: data moves in eight-bit bytes, each acknowledged by the receiver.
// RQ7: acknowledge driven after eighth clock falls, released on ninth fall.
// RQ8: master reading withholds final acknowledge; device then releases data.
// RQ9: first byte is seven-bit address, MSB first, then read/write bit.
// RQ10: respond only to target address 0110010.
// RQ11: start without stop is a repeated start; address is resent.
// RQ12: second write byte holds 4-bit pointer and 4-bit format; capture both. Code keeps only the pointer; the format just picks the next state.
// RQ13: master writes with format 0000 only.
// RQ14: third write byte goes to pointed register; pointer then advances.
// RQ15: pointer F wraps to 0 on the next byte, reads and writes.
// RQ16: every stop loads the pointer with F.
// RQ17: standard read is pointer write, repeated start, read address.
// RQ18: format 4 starts transmitting right after the pointer byte acknowledge.
// RQ19: read address straight after start sends from the current pointer.
// RQ20: consecutive reads auto-increment with wrap, E F 0 1.
// RQ21: device only pulls data low or releases it.
// RQ22: access open past half a second ends as a stop, pointer F.
// RQ23: after timeout, writes are not acknowledged and reads give all ones.
// RQ24: master waits 61 us after a stop before a new start.
// RQ25: foreign address leaves data released until the next start.
// RQ26: send next byte after acknowledge; release after a missing one.
`default_nettype none
module rtc_i2c_slave_interface #(
  parameter int unsigned TIMEOUT_CYCLES = rtci_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [3:0] rdAddr,
  input wire logic [7:0] rdData,
  output logic wrValid,
  output logic [3:0] wrAddr,
  output logic [7:0] wrData,
  input wire logic wrReady,
  output logic accessOpen
);
  typedef struct packed {
    rtci_pkg::rtci_state_t st;
    logic [3:0] bitCnt;
    logic inAck;
    logic [7:0] shReg;
    logic [7:0] txReg;
    logic txMode;
    logic ackNack;
    logic [3:0] ptr;
    logic sdaOe;
    logic sdaOut;
    logic accessOpen;
    logic timedOut;
    logic [rtci_pkg::TIMEOUT_CNT_W-1:0] toCnt;
    logic sclD;
    logic sdaD;
  } rtci_top_t;

  rtci_top_t q_r;
  rtci_top_t q_nxt;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic toHit;
  logic byteDone;
  logic pushValid;
  logic bufReady;
  logic [rtci_pkg::BUF_WIDTH-1:0] pushWord;

  rtci_sync2 #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din({sclIn, sdaIn}),
    .dout(pinSync)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];
  assign sclRise = sclS & ~q_r.sclD;
  assign sclFall = ~sclS & q_r.sclD;
  // only the master makes these; the device just watches
  assign startEv = sclS & q_r.sclD & q_r.sdaD & ~sdaS; // RQ3 RQ5
  assign stopEv = sclS & q_r.sclD & ~q_r.sdaD & sdaS; // RQ4 RQ5
  assign toHit = q_r.accessOpen &&
    (q_r.toCnt == TIMEOUT_CYCLES - 1); // RQ22
  assign byteDone = sclFall & ~q_r.inAck & (q_r.bitCnt == rtci_pkg::BITS_PER_BYTE);

  always_comb begin
    logic [7:0] nextByte;
    nextByte = rtci_pkg::IDLE_READ_BYTE;
    q_nxt = q_r;
    pushValid = 1'b0;
    pushWord = {q_r.ptr, q_r.shReg};
    q_nxt.sclD = sclS;
    q_nxt.sdaD = sdaS;
    q_nxt.sdaOut = 1'b0; // RQ21
    if (sclRise) begin
      if (q_r.inAck) begin
        q_nxt.ackNack = sdaS;
      end else if (q_r.bitCnt < rtci_pkg::BITS_PER_BYTE) begin
        q_nxt.shReg = {q_r.shReg[6:0], sdaS}; // RQ9 RQ6
        q_nxt.bitCnt = q_r.bitCnt + 4'h1;
      end
    end
    if (sclFall) begin
      if (q_r.inAck) begin
        // ninth clock fell: release, or carry on as transmitter
        q_nxt.inAck = 1'b0;
        q_nxt.bitCnt = 4'h0;
        q_nxt.sdaOe = 1'b0; // RQ7
        if (q_r.st == rtci_pkg::ST_RDATA) begin
          if (q_r.txMode && q_r.ackNack) begin
            q_nxt.st = rtci_pkg::ST_IGNORE; // RQ8 RQ26
            q_nxt.txMode = 1'b0;
          end else begin
            nextByte = q_r.timedOut ? rtci_pkg::IDLE_READ_BYTE : rdData;
            q_nxt.txReg = nextByte;
            q_nxt.txMode = 1'b1;
            q_nxt.sdaOe = ~nextByte[7]; // RQ26 RQ19 RQ17
            q_nxt.ptr = q_r.ptr + 4'h1; // RQ20 RQ15
          end
        end
      end else if (q_r.bitCnt == rtci_pkg::BITS_PER_BYTE) begin
        q_nxt.inAck = 1'b1;
        if (q_r.txMode) begin
          q_nxt.sdaOe = 1'b0; // RQ7
        end else begin
          case (q_r.st)
            rtci_pkg::ST_ADDR: begin
              if (q_r.shReg[7:1] == rtci_pkg::TARGET_ADDR) begin
                q_nxt.sdaOe = 1'b1; // RQ10 RQ6
                q_nxt.st = q_r.shReg[0] ? rtci_pkg::ST_RDATA : rtci_pkg::ST_PTR; // RQ9
              end else begin
                q_nxt.st = rtci_pkg::ST_IGNORE; // RQ25
              end
            end
            rtci_pkg::ST_PTR: begin
              q_nxt.ptr = q_r.shReg[7:4]; // RQ12
              q_nxt.sdaOe = 1'b1;
              // any format other than auto-read is taken as a write
              if (q_r.shReg[3:0] == rtci_pkg::FMT_AUTO_READ) begin
                q_nxt.st = rtci_pkg::ST_RDATA; // RQ18
              end else begin
                q_nxt.st = rtci_pkg::ST_WDATA; // RQ13 RQ17
              end
            end
            rtci_pkg::ST_WDATA: begin
              // a full buffer cannot be stretched out, so the byte is refused
              if (bufReady) begin
                pushValid = 1'b1; // RQ14
                q_nxt.ptr = q_r.ptr + 4'h1; // RQ15
                q_nxt.sdaOe = 1'b1;
              end
            end
            default: begin
              q_nxt.sdaOe = 1'b0;
            end
          endcase
        end
      end else if (q_r.txMode) begin
        q_nxt.txReg = {q_r.txReg[6:0], 1'b1};
        q_nxt.sdaOe = ~q_r.txReg[6]; // RQ2
      end
    end
    if (q_r.accessOpen) begin
      q_nxt.toCnt = q_r.toCnt + 32'h1;
    end
    if (toHit) begin
      q_nxt.accessOpen = 1'b0; // RQ22
      q_nxt.ptr = rtci_pkg::PTR_AFTER_STOP;
      q_nxt.timedOut = 1'b1;
      q_nxt.st = rtci_pkg::ST_IGNORE; // RQ23
      q_nxt.sdaOe = 1'b0;
      q_nxt.txMode = 1'b0;
    end
    if (startEv) begin
      // repeated start keeps the access and its timeout running
      q_nxt.bitCnt = 4'h0;
      q_nxt.inAck = 1'b0;
      q_nxt.sdaOe = 1'b0;
      q_nxt.txMode = 1'b0;
      q_nxt.st = q_r.timedOut ? rtci_pkg::ST_IGNORE : rtci_pkg::ST_ADDR; // RQ3 RQ11 RQ23
      if (!q_r.accessOpen && !q_r.timedOut) begin
        q_nxt.accessOpen = 1'b1;
        q_nxt.toCnt = 32'h0;
      end
    end
    if (stopEv) begin
      q_nxt.st = rtci_pkg::ST_IDLE; // RQ4 RQ1
      q_nxt.ptr = rtci_pkg::PTR_AFTER_STOP; // RQ16
      q_nxt.accessOpen = 1'b0;
      q_nxt.timedOut = 1'b0;
      q_nxt.sdaOe = 1'b0;
      q_nxt.txMode = 1'b0;
      q_nxt.inAck = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.st <= rtci_pkg::ST_IDLE;
      q_r.ptr <= rtci_pkg::PTR_AFTER_STOP;
      q_r.sclD <= 1'b1;
      q_r.sdaD <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  rtci_wbuf u_wbuf (
    .clk(clk),
    .srst(srst),
    .inValid(pushValid),
    .inData(pushWord),
    .inReady(bufReady),
    .outValid(wrValid),
    .outData({wrAddr, wrData}),
    .outReady(wrReady)
  );

  assign sdaOut = q_r.sdaOut;
  assign sdaOe = q_r.sdaOe;
  assign rdAddr = q_r.ptr;
  assign accessOpen = q_r.accessOpen;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_ackEnd;
    sclFall && q_r.inAck && (q_r.st == rtci_pkg::ST_RDATA);
  endsequence

  sequence s_masterAck;
    s_ackEnd ##0 (!q_r.txMode || !q_r.ackNack);
  endsequence

  sequence s_masterNack;
    s_ackEnd ##0 (q_r.txMode && q_r.ackNack);
  endsequence

  a_idle_released: assert property ( // RQ1
    (q_r.st == rtci_pkg::ST_IDLE) |-> !q_r.sdaOe)
    else $error("data driven while idle");

  a_sda_change_low: assert property ( // RQ2
    $changed(q_r.sdaOe) |-> !$past(sclS) || $past(startEv || stopEv || toHit))
    else $error("data changed while serial clock high");

  a_start_addr: assert property ( // RQ3
    (startEv && !q_r.timedOut) |=> (q_r.st == rtci_pkg::ST_ADDR) && (q_r.bitCnt == 4'h0))
    else $error("start did not begin address phase");

  a_stop_pointer: assert property ( // RQ16
    stopEv |=> (q_r.ptr == rtci_pkg::PTR_AFTER_STOP) && (q_r.st == rtci_pkg::ST_IDLE)
      && !q_r.accessOpen)
    else $error("stop did not reset pointer");

  a_addr_ack: assert property ( // RQ10
    (byteDone && (q_r.st == rtci_pkg::ST_ADDR) && !q_r.txMode
      && (q_r.shReg[7:1] == rtci_pkg::TARGET_ADDR) && !startEv && !stopEv && !toHit)
      |=> q_r.sdaOe && q_r.inAck)
    else $error("own address not acknowledged");

  a_addr_foreign: assert property ( // RQ25
    (byteDone && (q_r.st == rtci_pkg::ST_ADDR) && !q_r.txMode
      && (q_r.shReg[7:1] != rtci_pkg::TARGET_ADDR) && !startEv && !stopEv)
      |=> (q_r.st == rtci_pkg::ST_IGNORE) && !q_r.sdaOe)
    else $error("foreign address answered");

  a_ptr_capture: assert property ( // RQ12
    (byteDone && (q_r.st == rtci_pkg::ST_PTR) && !startEv && !stopEv && !toHit)
      |=> q_r.ptr == $past(q_r.shReg[7:4]))
    else $error("pointer not captured");

  a_auto_read: assert property ( // RQ18
    (byteDone && (q_r.st == rtci_pkg::ST_PTR) && !startEv && !stopEv && !toHit
      && (q_r.shReg[3:0] == rtci_pkg::FMT_AUTO_READ)) |=> q_r.st == rtci_pkg::ST_RDATA)
    else $error("auto read not entered");

  a_write_push: assert property ( // RQ14
    (byteDone && (q_r.st == rtci_pkg::ST_WDATA) && bufReady && !startEv && !stopEv && !toHit)
      |-> pushValid ##1 (q_r.ptr == 4'($past(q_r.ptr) + 4'h1)))
    else $error("write byte not stored or pointer not advanced");

  a_read_next: assert property ( // RQ20
    (s_masterAck ##0 (!startEv && !stopEv && !toHit))
      |=> q_r.txMode && (q_r.ptr == 4'($past(q_r.ptr) + 4'h1)))
    else $error("read pointer did not advance");

  a_read_nack: assert property ( // RQ26
    (s_masterNack ##0 (!startEv && !stopEv && !toHit))
      |=> ((q_r.st == rtci_pkg::ST_IGNORE) && !q_r.sdaOe) [*2])
    else $error("data held after missing acknowledge");

  a_timeout_end: assert property ( // RQ22
    (toHit && !stopEv && !startEv) |=> q_r.timedOut && (q_r.ptr == rtci_pkg::PTR_AFTER_STOP)
      && !q_r.accessOpen)
    else $error("timeout did not end access");

  a_timeout_silent: assert property ( // RQ23
    q_r.timedOut |-> !q_r.sdaOe)
    else $error("data driven after timeout");

  a_open_drain: assert property ( // RQ21
    !sdaOut)
    else $error("data driven high");

  // ack is let go on the ninth fall unless the device goes on sending
  a_ack_release: assert property ( // RQ7
    (sclFall && q_r.inAck && (q_r.st != rtci_pkg::ST_RDATA)) |=> !q_r.sdaOe)
    else $error("acknowledge held past ninth clock");

  a_ptr_wrap: assert property ( // RQ15
    (byteDone && (q_r.st == rtci_pkg::ST_WDATA) && bufReady && (q_r.ptr == 4'hF)
      && !startEv && !stopEv && !toHit) |=> (q_r.ptr == 4'h0))
    else $error("pointer did not wrap");

  a_read_load: assert property ( // RQ19
    (s_masterAck ##0 (!startEv && !stopEv && !toHit)) |=> (q_r.txReg == $past(rdData)))
    else $error("read byte not loaded from pointed register");

  a_ignore_silent: assert property ( // RQ25
    (q_r.st == rtci_pkg::ST_IGNORE) |-> !q_r.sdaOe)
    else $error("data driven while ignoring the bus");
endmodule
`default_nettype wire

// *** src/rtci_pkg.sv ***
// Purpose: shared constants and types of the clock's two-wire target interface
// Assumes: 10 MHz system clock
// Notes: serial clock and data arrive asynchronously and are resynchronised
`default_nettype none
package rtci_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam logic [6:0] TARGET_ADDR = 7'h32;
  localparam logic [3:0] PTR_AFTER_STOP = 4'hF;
  localparam logic [3:0] FMT_WRITE = 4'h0;
  localparam logic [3:0] FMT_AUTO_READ = 4'h4;
  localparam logic [7:0] IDLE_READ_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned BUF_WIDTH = 12;
  localparam int unsigned TIMEOUT_MS = 500;
  localparam int unsigned TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned TIMEOUT_CNT_W = 32;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } rtci_state_t;
endpackage
`default_nettype wire

// *** src/rtci_sync2.sv ***
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes: only the second stage is visible outside
`default_nettype none
module rtci_sync2 #(
  parameter int unsigned W = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rtci_sync_t;

  rtci_sync_t q_r;
  rtci_sync_t q_nxt;

  always_comb begin
    q_nxt.s1 = din;
    q_nxt.s2 = q_r.s1;
  end

  // idle bus is high on both wires
  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign dout = q_r.s2;
endmodule
`default_nettype wire

// *** src/rtci_wbuf.sv ***
// Purpose: two-entry buffer between byte capture and the register write port
// Assumes: one push and one pop per cycle at most
// Notes: head entry and valid are flops so outputs are registered
`default_nettype none
module rtci_wbuf (
  input wire logic clk,
  input wire logic srst,
  input wire logic inValid,
  input wire logic [rtci_pkg::BUF_WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [rtci_pkg::BUF_WIDTH-1:0] outData,
  input wire logic outReady
);
  typedef struct packed {
    logic v0;
    logic v1;
    logic [rtci_pkg::BUF_WIDTH-1:0] d0;
    logic [rtci_pkg::BUF_WIDTH-1:0] d1;
  } rtci_buf_t;

  rtci_buf_t q_r;
  rtci_buf_t q_nxt;
  logic push;
  logic pop;

  always_comb begin
    q_nxt = q_r;
    push = inValid & ~q_r.v1;
    pop = q_r.v0 & outReady;
    if (pop) begin
      if (q_r.v1) begin
        q_nxt.d0 = q_r.d1;
        q_nxt.v1 = 1'b0;
      end else if (push) begin
        q_nxt.d0 = inData;
      end else begin
        q_nxt.v0 = 1'b0;
      end
    end else if (push) begin
      if (!q_r.v0) begin
        q_nxt.d0 = inData;
        q_nxt.v0 = 1'b1;
      end else begin
        q_nxt.d1 = inData;
        q_nxt.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign inReady = ~q_r.v1;
  assign outValid = q_r.v0;
  assign outData = q_r.d0;
endmodule
`default_nettype wire

// *** test/rtc_i2c_slave_interface_bench.sv ***
// Purpose: self-checking bench for the two-wire target interface
// Assumes: register file modelled here; reads before writes
// Notes: access timeout shortened to 2000 clocks
`default_nettype none
module rtc_i2c_slave_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 2000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wrReady = 1'b1;
  logic sdaOut, sdaOe, wrValid, accessOpen, hostSclLow, hostSdaLow, sclLine, sdaLine;
  logic [3:0] rdAddr, wrAddr;
  logic [7:0] wrData, rdData;
  logic [7:0] regs [16];
  int err_total = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  // pull-ups: a line is low only while someone pulls it
  assign sclLine = ~hostSclLow;
  assign sdaLine = ~(hostSdaLow | (sdaOe & ~sdaOut));
  assign rdData = regs[rdAddr];
  rtc_i2c_slave_interface #(.TIMEOUT_CYCLES(TO_CYC)) uut (.clk(clk), .srst(srst),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .rdAddr(rdAddr),
    .rdData(rdData), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
    .wrReady(wrReady), .accessOpen(accessOpen));
  rtci_host_model host (.sdaLine(sdaLine), .sclLow(hostSclLow), .sdaLow(hostSdaLow));
  always @(posedge clk) if (wrValid === 1'b1 && wrReady) regs[wrAddr] <= wrData;
  always @(posedge clk) begin
    if (!srst && sdaOe === 1'b1 && sdaOut !== 1'b0) begin
      err_total++;
      $display("BAD sdaOut expected 0 seen %b", sdaOut);
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic addrPhase(input logic [7:0] a, input logic expAck);
    logic ack;
    host.busStart();
    host.sendByte(a, ack);
    chk("address ack", 8'(expAck), 8'(ack));
  endtask
  task automatic send(input logic [7:0] b, input logic expAck);
    logic ack;
    host.sendByte(b, ack);
    chk("byte ack", 8'(expAck), 8'(ack));
  endtask
  // expected read data is the power-up pattern 30h plus index
  task automatic readRun(input logic [3:0] first, input int n);
    logic [7:0] b;
    logic [3:0] idx;
    idx = first;
    for (int i = 0; i < n; i++) begin
      host.readByte(i == n - 1, b);
      chk("read byte", 8'h30 + 8'(idx), b);
      idx = idx + 4'h1;
    end
  endtask
  task automatic scReadAfterStop();
    addrPhase(8'h65, 1'b1);
    chk("open", 8'h01, 8'(accessOpen));
    readRun(4'hF, 2);
    host.busStop();
    chk("open", 8'h00, 8'(accessOpen));
  endtask
  task automatic scStandardRead();
    addrPhase(8'h64, 1'b1);
    send(8'h20, 1'b1);
    addrPhase(8'h65, 1'b1);
    readRun(4'h2, 3);
    host.busStop();
  endtask
  task automatic scAutoRead();
    addrPhase(8'h64, 1'b1);
    send(8'hE4, 1'b1);
    readRun(4'hE, 4);
    host.busStop();
  endtask
  task automatic scWrite();
    addrPhase(8'h64, 1'b1);
    send(8'hE0, 1'b1);
    send(8'h5A, 1'b1);
    send(8'hA5, 1'b1);
    send(8'h3C, 1'b1);
    host.busStop();
    chk("reg E", 8'h5A, regs[4'hE]);
    chk("reg F", 8'hA5, regs[4'hF]);
    chk("reg 0", 8'h3C, regs[4'h0]);
    chk("pointer", 8'h0F, 8'(rdAddr));
  endtask
  task automatic scForeign();
    addrPhase(8'h66, 1'b0);
    send(8'h00, 1'b0);
    host.busStop();
  endtask
  // receiver stalls: two words fit, the third is refused
  task automatic scStall();
    @(posedge clk);
    #1 wrReady = 1'b0;
    addrPhase(8'h64, 1'b1);
    send(8'h50, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b0);
    host.busStop();
    chk("wrValid held", 8'h01, 8'(wrValid));
    chk("wrAddr held", 8'h05, 8'(wrAddr));
    @(posedge clk);
    #1 wrReady = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("reg 5", 8'h11, regs[4'h5]);
    chk("reg 6", 8'h22, regs[4'h6]);
    chk("reg 7", 8'h37, regs[4'h7]);
    chk("wrValid drained", 8'h00, 8'(wrValid));
  endtask
  task automatic scTimeout();
    logic [7:0] b;
    addrPhase(8'h64, 1'b1);
    repeat (TO_CYC + 100) @(posedge clk);
    #1;
    chk("open", 8'h00, 8'(accessOpen));
    chk("pointer", 8'h0F, 8'(rdAddr));
    send(8'h12, 1'b0);
    // repeated start is ignored too; the line floats to all ones
    addrPhase(8'h65, 1'b0);
    host.readByte(1'b1, b);
    chk("timed out read", 8'hFF, b);
    host.busStop();
  endtask
  initial begin
    for (int i = 0; i < 16; i++) regs[i] = 8'h30 + 8'(i);
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    // host delays are all whole clock periods, so this keeps pins off the edge
    #1;
    scReadAfterStop();
    scStandardRead();
    scAutoRead();
    scWrite();
    scForeign();
    scStall();
    scTimeout();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("BAD run length expected end seen hang");
    final_report();
  end
endmodule
`default_nettype wire

// *** test/rtci_host_model.sv ***
// Purpose: bus master model for the two-wire link
// Assumes: 800 ns per bit; both lines have pull-ups outside
// Notes: byte tasks start and end just after the serial clock falls; busStop ends with the clock high
`default_nettype none
module rtci_host_model (
  input wire logic sdaLine,
  output logic sclLow,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // mid-frame start waits out the device's ack before lifting the clock
  task automatic busStart();
    if (sclLow) begin
      sdaLow = 1'b0;
      #400 sclLow = 1'b0;
      #400;
    end
    sdaLow = 1'b1;
    #400 sclLow = 1'b1;
  endtask
  task automatic busStop();
    sdaLow = 1'b1;
    #400 sclLow = 1'b0;
    #400 sdaLow = 1'b0;
    #61000;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #200 sdaLow = ~b[i];
      #200 sclLow = 1'b0;
      #400 sclLow = 1'b1;
    end
    #200 sdaLow = 1'b0;
    #200 sclLow = 1'b0;
    #200 ack = ~sdaLine;
    #200 sclLow = 1'b1;
  endtask
  task automatic readByte(input logic lastByte, output logic [7:0] b);
    sdaLow = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #400 sclLow = 1'b0;
      #200 b[i] = sdaLine;
      #200 sclLow = 1'b1;
    end
    #200 sdaLow = ~lastByte;
    #200 sclLow = 1'b0;
    #400 sclLow = 1'b1;
  endtask
endmodule
`default_nettype wire
